// file: verilog/cmb_pkg.sv
/*
 * Shared constants, types and helpers of the CAN message box.
 * Assumes a 32-bit classic Wishbone register bus and one clock at 200 MHz.
 */
package cmb_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADR_MODE      = 8'h00;
  localparam logic [7:0] ADR_FILT_FLG  = 8'h04;
  localparam logic [7:0] ADR_FILT_ID   = 8'h08;
  localparam logic [7:0] ADR_PKT_FLG   = 8'h0c;
  localparam logic [7:0] ADR_PKT_ID    = 8'h10;
  localparam logic [7:0] ADR_PKT_LEN   = 8'h14;
  localparam logic [7:0] ADR_PKT_DLO   = 8'h18;
  localparam logic [7:0] ADR_PKT_DHI   = 8'h1c;
  localparam logic [7:0] ADR_PKT_CYC   = 8'h20;
  localparam logic [7:0] ADR_FRM_CNT   = 8'h24;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h28;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h2c;

  // ----------------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------------
  localparam int          FLG_IDE_BIT  = 7;
  localparam int          FLG_RTR_BIT  = 6;
  localparam logic [7:0]  MODE_OFF     = 8'h00;
  localparam logic [7:0]  MODE_SEND    = 8'h01;
  localparam logic [7:0]  MODE_RECV    = 8'h02;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [3:0]  LEN_MAX      = 4'h8;
  localparam logic [28:0] STD_ID_MASK  = 29'h0000_07ff;
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;
  localparam logic [7:0]  CNT_CLR_VAL  = 8'h00;
  localparam logic [3:0]  SEL_BYTE0    = 4'h1;
  localparam int          IRQ_TX       = 0;
  localparam int          IRQ_RX       = 1;
  localparam int          IRQ_ERR      = 2;
  localparam int          IRQ_W        = 3;
  localparam logic [2:0]  IRQ_RST      = 3'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int MS_TIME_US = 1000;
  localparam int CLK_MHZ    = 200;
  localparam int MS_CYCLES  = MS_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } cmb_state_t;

  typedef struct packed {
    logic        ide;
    logic        rtr;
    logic [28:0] id;
    logic [3:0]  len;
    logic [63:0] data;
  } cmb_frame_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [28:0] cmb_id(input logic ide,
                                         input logic [28:0] id);
    cmb_id = ide ? id : (id & STD_ID_MASK);
  endfunction

  function automatic logic [31:0] cmb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    cmb_merge = r;
  endfunction

endpackage

// file: verilog/cmb_ms_tick.sv
/*
 * Millisecond tick generator for the CAN message box.
 * Assumes the parent holds restart high whenever no period is running.
 */
`timescale 1ns/1ps
module cmb_ms_tick #(
  parameter int CYCLES = cmb_pkg::MS_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  logic [31:0] div_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      div_q <= 32'h0000_0000;
    end else if (div_q == LAST) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (div_q == LAST);
    end
  end

endmodule

// file: verilog/cmb_box.sv
/*
 * One CAN message box: send once or periodically, or capture the latest
 * frame matching a filter, with a frame counter and interrupt events.
 * Assumes a same-clock CAN controller: tx frame held until tx_ready_i,
 * and rx_valid_i pulses for one cycle per received frame.
 */
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Operation
// - Standard packet: flags IDE bit7 RTR bit6, 11-bit identifier, length, data, cycle.
// - Extended packet: flags, 29-bit identifier, length, up to eight bytes, cycle.
// - Remote flag writes ignored; flag always reads zero.
// - Counter reads 32-bit, resets zero; byte-zero write clears, others error.
// - Counter increments per transmitted frame and per matching received frame; the code adds only one when both land in the same cycle.
// - Inactive box idles; filter and packet remain writable.
// - Send mode retransmits each cycle-time milliseconds.
// - Zero cycle time sends once then returns mode to inactive.
// - Each transmission raises a notification when subscribed.
// - Send mode accepts filter and packet writes; new packet used next time.
// - Several send boxes may share one identifier.
// - Matching received frame replaces packet and notifies when subscribed.
// - Receive mode rejects filter and packet writes; packet shows last frame.
// - Mode byte 0 inactive, 1 send, 2 receive; reset inactive; others error.
module cmb_box #(
  parameter int MS_CYCLES = cmb_pkg::MS_CYCLES
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     irq_o,
  output cmb_pkg::cmb_frame_t      tx_frame_o,
  output logic                     tx_valid_o,
  input  wire logic                tx_ready_i,
  input  wire cmb_pkg::cmb_frame_t rx_frame_i,
  input  wire logic                rx_valid_i
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cmb_pkg::cmb_state_t state_q;
  cmb_pkg::cmb_frame_t pkt_q;
  logic [7:0]          mode_q;
  logic                filt_ide_q;
  logic [28:0]         filt_id_q;
  logic [31:0]         cyc_time_q;
  logic [31:0]         cnt_q;
  logic [31:0]         ms_cnt_q;
  logic                once_q;
  logic [2:0]          irq_stat_q;
  logic [2:0]          irq_mask_q;
  logic [31:0]         rdata;
  logic [31:0]         wmerge;
  logic                req;
  logic                wr;
  logic                rd;
  logic                is_send;
  logic                is_recv;
  logic                tx_done;
  logic                rx_hit;
  logic                tick;
  logic                mode_ok;
  logic                mode_wr;
  logic                cnt_clr;
  logic                cfg_wr;
  logic                err_ev;

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  // Writes land at the ack edge, which is when the master samples ack.
  assign req     = wb_cyc_i && wb_stb_i;
  assign wr      = req && wb_ack_o && wb_we_i;
  assign rd      = req && wb_ack_o && !wb_we_i;
  assign is_send = (mode_q == cmb_pkg::MODE_SEND);
  assign is_recv = (mode_q == cmb_pkg::MODE_RECV);
  assign wmerge  = cmb_pkg::cmb_merge(rdata, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i == cmb_pkg::ADR_MODE) begin
      rdata[7:0] = mode_q;
    end else if (wb_adr_i == cmb_pkg::ADR_FILT_FLG) begin
      rdata[cmb_pkg::FLG_IDE_BIT] = filt_ide_q;
    end else if (wb_adr_i == cmb_pkg::ADR_FILT_ID) begin
      rdata[28:0] = cmb_pkg::cmb_id(filt_ide_q, filt_id_q);
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_FLG) begin
      rdata[cmb_pkg::FLG_IDE_BIT] = pkt_q.ide;
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_ID) begin
      rdata[28:0] = cmb_pkg::cmb_id(pkt_q.ide, pkt_q.id);
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_LEN) begin
      rdata[3:0] = pkt_q.len;
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_DLO) begin
      rdata = pkt_q.data[31:0];
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_DHI) begin
      rdata = pkt_q.data[63:32];
    end else if (wb_adr_i == cmb_pkg::ADR_PKT_CYC) begin
      rdata = cyc_time_q;
    end else if (wb_adr_i == cmb_pkg::ADR_FRM_CNT) begin
      rdata = cnt_q;
    end else if (wb_adr_i == cmb_pkg::ADR_IRQ_STAT) begin
      rdata[2:0] = irq_stat_q;
    end else if (wb_adr_i == cmb_pkg::ADR_IRQ_MASK) begin
      rdata[2:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Write checks
  // ----------------------------------------------------------------------
  assign mode_ok = (wmerge[7:0] == cmb_pkg::MODE_OFF) ||
                   (wmerge[7:0] == cmb_pkg::MODE_SEND) ||
                   (wmerge[7:0] == cmb_pkg::MODE_RECV);
  assign mode_wr = wr && (wb_adr_i == cmb_pkg::ADR_MODE) && mode_ok;
  assign cnt_clr = wr && (wb_adr_i == cmb_pkg::ADR_FRM_CNT) &&
                   (wb_sel_i == cmb_pkg::SEL_BYTE0) &&
                   (wb_dat_i[7:0] == cmb_pkg::CNT_CLR_VAL);
  // Filter and packet writes are locked only while receiving.
  assign cfg_wr  = wr && !is_recv;

  always_comb begin
    err_ev = 1'b0;
    if (wr && (wb_adr_i == cmb_pkg::ADR_MODE) && !mode_ok) begin
      err_ev = 1'b1;
    end else if (wr && (wb_adr_i == cmb_pkg::ADR_FRM_CNT) && !cnt_clr) begin
      err_ev = 1'b1;
    end else if (wr && is_recv && (wb_adr_i >= cmb_pkg::ADR_FILT_FLG) &&
                 (wb_adr_i <= cmb_pkg::ADR_PKT_CYC)) begin
      err_ev = 1'b1;
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_LEN) &&
                 (wmerge[3:0] > cmb_pkg::LEN_MAX)) begin
      err_ev = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Mode
  // ----------------------------------------------------------------------
  // A software mode write in the same cycle beats the one-shot fallback.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= cmb_pkg::MODE_RST;
    end else if (mode_wr) begin
      mode_q <= wmerge[7:0];
    end else if (tx_done && once_q && is_send) begin
      mode_q <= cmb_pkg::MODE_OFF;
    end
  end

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_ide_q <= 1'b0;
      filt_id_q  <= 29'h0000_0000;
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_FILT_FLG)) begin
      filt_ide_q <= wmerge[cmb_pkg::FLG_IDE_BIT];
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_FILT_ID)) begin
      filt_id_q  <= wmerge[28:0];
    end
  end

  // ----------------------------------------------------------------------
  // Packet
  // ----------------------------------------------------------------------
  assign rx_hit = is_recv && rx_valid_i &&
                  (rx_frame_i.ide == filt_ide_q) &&
                  (cmb_pkg::cmb_id(rx_frame_i.ide, rx_frame_i.id) ==
                   cmb_pkg::cmb_id(filt_ide_q, filt_id_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_q      <= '0;
      cyc_time_q <= 32'h0000_0000;
    end else if (rx_hit) begin
      pkt_q      <= rx_frame_i;
      pkt_q.id   <= cmb_pkg::cmb_id(rx_frame_i.ide, rx_frame_i.id);
      pkt_q.rtr  <= 1'b0;
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_FLG)) begin
      pkt_q.ide  <= wmerge[cmb_pkg::FLG_IDE_BIT];
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_ID)) begin
      pkt_q.id   <= wmerge[28:0];
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_LEN) &&
                 (wmerge[3:0] <= cmb_pkg::LEN_MAX)) begin
      pkt_q.len  <= wmerge[3:0];
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_DLO)) begin
      pkt_q.data[31:0]  <= wmerge;
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_DHI)) begin
      pkt_q.data[63:32] <= wmerge;
    end else if (cfg_wr && (wb_adr_i == cmb_pkg::ADR_PKT_CYC)) begin
      cyc_time_q <= wmerge;
    end
  end

  // ----------------------------------------------------------------------
  // Send sequencer
  // ----------------------------------------------------------------------
  // Frame is latched at launch, so packet edits apply to the next send.
  // No identifier check across boxes: duplicates on send are legal.
  assign tx_valid_o = (state_q == cmb_pkg::ST_SEND);
  assign tx_done    = tx_valid_o && tx_ready_i;

  cmb_ms_tick #(
    .CYCLES    (MS_CYCLES)
  ) u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (state_q != cmb_pkg::ST_WAIT),
    .tick_o    (tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= cmb_pkg::ST_IDLE;
      tx_frame_o <= '0;
      once_q     <= 1'b0;
      ms_cnt_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        cmb_pkg::ST_IDLE: begin
          if (is_send) begin
            state_q        <= cmb_pkg::ST_SEND;
            tx_frame_o     <= pkt_q;
            tx_frame_o.id  <= cmb_pkg::cmb_id(pkt_q.ide, pkt_q.id);
            tx_frame_o.rtr <= 1'b0;
            once_q         <= (cyc_time_q == 32'h0000_0000);
          end
        end
        cmb_pkg::ST_SEND: begin
          // A started frame always completes; the controller owns it.
          if (tx_done) begin
            ms_cnt_q <= 32'h0000_0000;
            if (once_q || !is_send) begin
              state_q <= cmb_pkg::ST_IDLE;
            end else begin
              state_q <= cmb_pkg::ST_WAIT;
            end
          end
        end
        cmb_pkg::ST_WAIT: begin
          if (!is_send) begin
            state_q <= cmb_pkg::ST_IDLE;
          end else if (tick) begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
            if ((ms_cnt_q + 32'h0000_0001) >= cyc_time_q) begin
              state_q        <= cmb_pkg::ST_SEND;
              tx_frame_o     <= pkt_q;
              tx_frame_o.id  <= cmb_pkg::cmb_id(pkt_q.ide, pkt_q.id);
              tx_frame_o.rtr <= 1'b0;
              once_q         <= (cyc_time_q == 32'h0000_0000);
            end
          end
        end
        default: begin
          state_q <= cmb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Frame counter
  // ----------------------------------------------------------------------
  // A frame in the clearing cycle still counts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= cmb_pkg::CNT_RST;
    end else if (cnt_clr) begin
      cnt_q <= (tx_done || rx_hit) ? 32'h0000_0001 : 32'h0000_0000;
    end else if (tx_done || rx_hit) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // Read clears only the bits captured for that read; new events stay.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= cmb_pkg::IRQ_RST;
    end else begin
      if (rd && (wb_adr_i == cmb_pkg::ADR_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~wb_dat_o[2:0]) |
                      {err_ev, rx_hit, tx_done};
      end else begin
        irq_stat_q <= irq_stat_q | {err_ev, rx_hit, tx_done};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= cmb_pkg::IRQ_RST;
    end else if (wr && (wb_adr_i == cmb_pkg::ADR_IRQ_MASK)) begin
      irq_mask_q <= wmerge[2:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_rtr_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && (wb_adr_i == cmb_pkg::ADR_PKT_FLG ||
     wb_adr_i == cmb_pkg::ADR_FILT_FLG)) |-> !wb_dat_o[cmb_pkg::FLG_RTR_BIT])
    else $error("remote flag read as one");

  a_std_id_width: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && wb_adr_i == cmb_pkg::ADR_PKT_ID && !pkt_q.ide)
    |-> (wb_dat_o[31:11] == 21'h00_0000))
    else $error("standard identifier wider than 11 bits");

  a_cnt_counts_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_done && !cnt_clr) |=> (cnt_q == $past(cnt_q) + 32'h0000_0001))
    else $error("frame counter missed a transmission");

  a_cnt_bad_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == cmb_pkg::ADR_FRM_CNT && !cnt_clr && !tx_done &&
     !rx_hit) |=> (cnt_q == $past(cnt_q)) && irq_stat_q[cmb_pkg::IRQ_ERR])
    else $error("bad counter write not ignored");

  a_once_goes_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_done && once_q && is_send && !mode_wr)
    |=> (mode_q == cmb_pkg::MODE_OFF) ##1 !tx_valid_o)
    else $error("one-shot send did not return to inactive");

  a_send_starts: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == cmb_pkg::ST_IDLE && is_send) |=> tx_valid_o)
    else $error("send mode did not launch a frame");

  a_bad_mode_err: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == cmb_pkg::ADR_MODE && !mode_ok && !tx_done)
    |=> (mode_q == $past(mode_q)) && irq_stat_q[cmb_pkg::IRQ_ERR])
    else $error("unsupported mode value accepted");

  a_recv_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && is_recv && !rx_hit && wb_adr_i == cmb_pkg::ADR_PKT_DLO)
    |=> (pkt_q.data == $past(pkt_q.data)))
    else $error("packet written in receive mode");

  a_rx_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hit |=> (pkt_q.data == $past(rx_frame_i.data)) &&
               irq_stat_q[cmb_pkg::IRQ_RX])
    else $error("matching frame not captured");

  a_miss_no_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_valid_i && !rx_hit && !tx_done && !cnt_clr)
    |=> (cnt_q == $past(cnt_q)))
    else $error("unmatched frame changed the counter");

endmodule

// file: test/cmb_can_model.sv
/*
 * CAN controller model on the far side of the message box.
 * Assumes the bench sets lat and calls put() for each received frame.
 */
`timescale 1ns/1ps
module cmb_can_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire cmb_pkg::cmb_frame_t tx_frame_i,
  input  wire logic                tx_valid_i,
  output logic                     tx_ready_o,
  output cmb_pkg::cmb_frame_t      rx_frame_o,
  output logic                     rx_valid_o
);
  int                  lat = 0;
  int                  wait_q = 0;
  int                  n_tx = 0;
  int                  cyc_n = 0;
  int                  t_done = 0;
  cmb_pkg::cmb_frame_t last_f;
  initial begin
    rx_frame_o = '0;
    rx_valid_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // Transmit side: accepts after lat cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      wait_q     <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      tx_ready_o <= 1'b0;
      wait_q     <= 0;
      n_tx       <= n_tx + 1;
      last_f     <= tx_frame_i;
      t_done     <= cyc_n;
    end else if (tx_valid_i) begin
      if (wait_q >= lat) tx_ready_o <= 1'b1;
      else wait_q <= wait_q + 1;
    end
  end
  // Lines scrambled after the pulse, never left showing the frame
  task automatic put(input cmb_pkg::cmb_frame_t f);
    @(posedge clk_i);
    rx_frame_o <= f;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_frame_o <= ~f;
    rx_valid_o <= 1'b0;
  endtask
endmodule

// file: test/test_can_message_box_send_receive.sv
/*
 * Self-checking bench of one CAN message box.
 * Assumes the model answers transmits; short millisecond of 20 cycles.
 */
`timescale 1ns/1ps
module test_can_message_box_send_receive;
  localparam int MS = 20;
  logic                clk_i = 0;
  logic                rst_i = 1;
  logic                cyc = 0, stb = 0, we = 0;
  logic [7:0]          adr = '0;
  logic [3:0]          sel = '0;
  logic [31:0]         dat = '0, rdat, v;
  logic                ack, irq, tx_valid, tx_ready, rx_valid;
  cmb_pkg::cmb_frame_t tx_frame, rx_frame, f;
  int                  miscompares = 0, n_compared = 0, cycles = 0, t0;
  always #2.5 clk_i = ~clk_i;
  cmb_box #(.MS_CYCLES(MS)) cmb_box_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .tx_frame_o(tx_frame), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .rx_frame_i(rx_frame), .rx_valid_i(rx_valid));
  cmb_can_model cmb_can_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .tx_frame_i(tx_frame), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_frame_o(rx_frame), .rx_valid_o(rx_valid));
  // ----------------------------------------------------------------
  // Bus cycles and checks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    v = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(v === e, "read value");
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < 2000 && cmb_can_model_inst.n_tx < n; i++)
      @(posedge clk_i);
    chk(cmb_can_model_inst.n_tx == n, "frame count on bus");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(cmb_pkg::ADR_MODE, 32'h0000_0000);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0000);
    wr(cmb_pkg::ADR_MODE, 32'h0000_0003);
    rd_chk(cmb_pkg::ADR_MODE, 32'h0000_0000);
    chk(irq === 1'b0, "masked error raised irq");
    rd_chk(cmb_pkg::ADR_IRQ_STAT, 32'h0000_0004);
    rd_chk(cmb_pkg::ADR_IRQ_STAT, 32'h0000_0000);
  endtask
  task automatic t_once;
    wr(cmb_pkg::ADR_IRQ_MASK, 32'h0000_0007);
    wr(cmb_pkg::ADR_PKT_FLG, 32'h0000_0040);
    wr(cmb_pkg::ADR_PKT_ID, 32'h0000_0fff);
    wr(cmb_pkg::ADR_PKT_LEN, 32'h0000_0009);
    rd_chk(cmb_pkg::ADR_PKT_LEN, 32'h0000_0000);
    wr(cmb_pkg::ADR_PKT_LEN, 32'h0000_0008);
    wr(cmb_pkg::ADR_PKT_DLO, 32'h3322_1100);
    wr(cmb_pkg::ADR_PKT_DHI, 32'h7766_5544);
    wr(cmb_pkg::ADR_PKT_CYC, 32'h0000_0000);
    rd_chk(cmb_pkg::ADR_PKT_FLG, 32'h0000_0000);
    rd_chk(cmb_pkg::ADR_PKT_ID, 32'h0000_07ff);
    wr(cmb_pkg::ADR_MODE, 32'h0000_0001);
    wait_tx(1);
    f = cmb_can_model_inst.last_f;
    chk(f.id === 29'h0000_07ff && f.rtr === 1'b0, "std frame");
    chk(f.ide === 1'b0 && f.len === 4'h8, "std frame len");
    chk(f.data === 64'h7766_5544_3322_1100, "frame data");
    repeat (3 * MS) @(posedge clk_i);
    chk(cmb_can_model_inst.n_tx == 1, "one shot repeated");
    rd_chk(cmb_pkg::ADR_MODE, 32'h0000_0000);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0001);
    chk(irq === 1'b1, "no tx notification");
    rd_chk(cmb_pkg::ADR_IRQ_STAT, 32'h0000_0005);
    @(posedge clk_i);
    chk(irq === 1'b0, "irq after clear");
  endtask
  task automatic t_period;
    cmb_can_model_inst.lat = 3;
    wr(cmb_pkg::ADR_PKT_FLG, 32'h0000_0080);
    wr(cmb_pkg::ADR_PKT_ID, 32'h1cff_ffff);
    wr(cmb_pkg::ADR_PKT_CYC, 32'h0000_0002);
    wr(cmb_pkg::ADR_MODE, 32'h0000_0001);
    wait_tx(3);
    t0 = cmb_can_model_inst.t_done;
    wr(cmb_pkg::ADR_PKT_DLO, 32'hcafe_f00d);
    wait_tx(4);
    t0 = cmb_can_model_inst.t_done - t0;
    chk(t0 >= 2 * MS && t0 <= 2 * MS + 8, "period");
    f = cmb_can_model_inst.last_f;
    chk(f.ide === 1'b1 && f.id === 29'h1cff_ffff, "ext frame");
    chk(f.data[31:0] === 32'hcafe_f00d, "update unused");
    wr(cmb_pkg::ADR_MODE, 32'h0000_0000);
    wr(cmb_pkg::ADR_PKT_CYC, 32'h0000_0000);
    repeat (4 * MS) @(posedge clk_i);
    chk(cmb_can_model_inst.n_tx == 4, "inactive box sent");
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0004);
    rd_chk(cmb_pkg::ADR_PKT_CYC, 32'h0000_0000);
  endtask
  task automatic t_recv;
    bus(1'b0, cmb_pkg::ADR_IRQ_STAT, 32'h0000_0000, 4'hf);
    wr(cmb_pkg::ADR_FILT_FLG, 32'h0000_0080);
    wr(cmb_pkg::ADR_FILT_ID, 32'h0123_4567);
    wr(cmb_pkg::ADR_MODE, 32'h0000_0002);
    f = '{1'b0, 1'b1, 29'h0123_4567, 4'h4, 64'h0000_0000_0bad_0bad};
    cmb_can_model_inst.put(f);
    f.ide = 1'b1;
    f.id = 29'h0123_4568;
    cmb_can_model_inst.put(f);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0004);
    f.id = 29'h0123_4567;
    f.data = 64'h0000_0000_1234_abcd;
    cmb_can_model_inst.put(f);
    rd_chk(cmb_pkg::ADR_PKT_DLO, 32'h1234_abcd);
    rd_chk(cmb_pkg::ADR_PKT_FLG, 32'h0000_0080);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0005);
    wr(cmb_pkg::ADR_PKT_DLO, 32'h5555_aaaa);
    wr(cmb_pkg::ADR_FILT_ID, 32'h0000_0001);
    rd_chk(cmb_pkg::ADR_PKT_DLO, 32'h1234_abcd);
    rd_chk(cmb_pkg::ADR_FILT_ID, 32'h0123_4567);
    rd_chk(cmb_pkg::ADR_IRQ_STAT, 32'h0000_0006);
  endtask
  task automatic t_count;
    bus(1'b1, cmb_pkg::ADR_FRM_CNT, 32'h0000_0005, 4'h1);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0005);
    rd_chk(cmb_pkg::ADR_IRQ_STAT, 32'h0000_0004);
    bus(1'b1, cmb_pkg::ADR_FRM_CNT, 32'h0000_0000, 4'h1);
    rd_chk(cmb_pkg::ADR_FRM_CNT, 32'h0000_0000);
  endtask
  // ----------------------------------------------------------------
  // Sequence, timeout and verdict
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_once;
    t_period;
    t_recv;
    t_count;
    stop_test;
  end
endmodule
